// File: rtl/ctb_top.sv
`timescale 1ns/1ps
module ctb_top #(
    parameter int NBUF = 32
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic rd_byte_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic can_rx_i,
    input wire ctb_pkg::ctb_evt_s evt_i,
    input wire ctb_pkg::ctb_eng_wr_s eng_i,
    output logic tq_tick_o,
    output logic sample_o,
    output logic bit_start_o,
    output logic [2:0] jump_width_o,
    output logic standby_o,
    output logic global_operate_o,
    output logic ch_irq_o,
    output logic glob_irq_o
);
    import ctb_pkg::*;

    localparam int MEMW = NBUF * 16;

    // Decode helpers shared by read, write and error paths
    function automatic logic mb_hit(input logic [11:0] a);
        mb_hit = (a >= CTB_MB_BASE) && (int'(a) < int'(CTB_MB_BASE) + NBUF * CTB_MB_STRIDE)
                 && (a[5:2] <= CTB_W_IDH);
    endfunction

    function automatic logic [CTB_BUF_W-1:0] mb_buf(input logic [11:0] a);
        logic [11:0] d;
        d = a - CTB_MB_BASE;
        mb_buf = d[10:6];
    endfunction

    function automatic int mem_idx(input logic [CTB_BUF_W-1:0] b, input logic [3:0] w);
        mem_idx = int'(b) * 16 + int'(w);
    endfunction

    logic [15:0] mem [MEMW];
    logic [15:0] tmp_reg [10];
    logic [15:0] tmp_next [10];
    logic [NBUF-1:0] nd_reg, nd_next;
    logic gom_reg, gom_next, forced_shutdown_enable_reg, forced_shutdown_enable_next;
    logic [3:0] gpend_reg, gpend_next, gien_reg, gien_next;
    logic [3:0] cpend_reg, cpend_next;
    logic [2:0] cien_reg, cien_next;
    logic init_reg, init_next;
    ctb_mode_e mode_reg, mode_next;
    logic [7:0] brp_reg, brp_next;
    logic [15:0] sync_reg, sync_next;
    logic ack_reg, ack_next;
    logic [31:0] prdata_reg, prdata_next;
    logic err_reg, err_next;
    logic burst_reg, burst_next;
    logic [CTB_BUF_W-1:0] bbuf_reg, bbuf_next;
    logic [3:0] blast_reg, blast_next;
    logic rx_s1, rx_s2, rx_s3;
    logic rx_fall;
    logic cap, fin, is_glob, is_ch, is_tmp, is_mb, undef, acc_err;
    logic burst_hit;
    logic [CTB_BUF_W-1:0] abuf;
    logic [3:0] aword;
    logic [15:0] evt_ctrl;

    // Request phases: capture in the first access cycle, complete in the second
    assign cap = psel_i & penable_i & ~ack_reg;
    assign fin = psel_i & penable_i & ack_reg;
    assign pready_o = fin;
    assign prdata_o = prdata_reg;
    assign pslverr_o = fin & err_reg;
    assign abuf = mb_buf(paddr_i);
    assign aword = paddr_i[5:2];
    assign is_glob = (paddr_i == CTB_GSTAT_ADDR) || (paddr_i == CTB_GPEND_ADDR)
                     || (paddr_i == CTB_GIEN_ADDR);
    assign is_ch = (paddr_i >= CTB_CCTRL_ADDR) && (paddr_i <= CTB_CPEND_ADDR)
                   && (paddr_i[1:0] == 2'h0);
    assign is_tmp = (paddr_i >= CTB_TMP_BASE + 12'h008) && (paddr_i <= CTB_TMP_LAST)
                    && (paddr_i[1:0] == 2'h0);
    assign is_mb = mb_hit(paddr_i) && (paddr_i[1:0] == 2'h0);
    assign undef = ~(is_glob | is_ch | is_tmp | is_mb);
    assign acc_err = undef | ((is_ch | is_mb) & ~gom_reg) | (is_tmp & gom_reg);
    // Linear follow-on read of the buffer that opened the burst
    assign burst_hit = burst_reg & ~rd_byte_i & is_mb & (abuf == bbuf_reg)
                       & (aword == blast_reg + 4'h1);
    assign evt_ctrl = mem[mem_idx(evt_i.buf_idx, CTB_W_CTRL)];
    assign rx_fall = rx_s3 & ~rx_s2;

    // Bus pin passes three flops; edge detect reads only the later two stages
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
        end else begin
            rx_s1 <= can_rx_i;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end

    // Register file, burst reader, pending flags and mode next values
    always_comb begin
        logic [3:0] gset;
        logic [3:0] cset;
        gset = 4'h0;
        cset = 4'h0;
        ack_next = cap;
        prdata_next = prdata_reg;
        err_next = err_reg;
        gom_next = gom_reg;
        forced_shutdown_enable_next = forced_shutdown_enable_reg;
        gien_next = gien_reg;
        cien_next = cien_reg;
        init_next = init_reg;
        mode_next = mode_reg;
        brp_next = brp_reg;
        sync_next = sync_reg;
        burst_next = burst_reg;
        bbuf_next = bbuf_reg;
        blast_next = blast_reg;
        nd_next = nd_reg;
        for (int k = 0; k < 10; k++) begin
            tmp_next[k] = tmp_reg[k];
        end
        // Read data, error status and read side effects at capture
        if (cap) begin
            err_next = acc_err;
            gset[CTB_G_UNDEF] = undef;
            gset[CTB_G_CHOFF] = (is_ch | is_mb) & ~gom_reg;
            gset[CTB_G_TMPON] = is_tmp & gom_reg;
            if (!pwrite_i) begin
                prdata_next = 32'h0000_0000;
                burst_next = 1'b0;
                if (!acc_err) begin
                    case (paddr_i)
                        CTB_GSTAT_ADDR: prdata_next = {30'h0, forced_shutdown_enable_reg, gom_reg};
                        CTB_GPEND_ADDR: prdata_next = {28'h0, gpend_reg};
                        CTB_GIEN_ADDR: prdata_next = {28'h0, gien_reg};
                        CTB_CCTRL_ADDR: prdata_next = {21'h0, mode_reg == CTB_STOP,
                            mode_reg == CTB_SLEEP, init_reg, 7'h0, init_reg};
                        CTB_CBRP_ADDR: prdata_next = {24'h0, brp_reg};
                        CTB_CSYNC_ADDR: prdata_next = {16'h0, sync_reg};
                        CTB_CIEN_ADDR: prdata_next = {29'h0, cien_reg};
                        CTB_CPEND_ADDR: prdata_next = {28'h0, cpend_reg};
                        default: begin
                            if (is_tmp) begin
                                prdata_next = {16'h0, tmp_reg[paddr_i[5:2]]};
                            end else if (burst_hit) begin
                                prdata_next = {16'h0, tmp_reg[aword]};
                                burst_next = (aword != CTB_W_IDH);
                                blast_next = aword;
                            end else if (aword == CTB_W_STATE) begin
                                prdata_next = {31'h0, nd_reg[abuf]};
                            end else begin
                                prdata_next = {16'h0, mem[mem_idx(abuf, aword)]};
                            end
                            // Word-wide length read snapshots the buffer
                            if (aword == CTB_W_LEN && !rd_byte_i && !is_tmp) begin
                                burst_next = 1'b1;
                                bbuf_next = abuf;
                                blast_next = CTB_W_LEN;
                                for (int k = 2; k < 10; k++) begin
                                    tmp_next[k] = mem[mem_idx(abuf, 4'(k))];
                                end
                            end
                        end
                    endcase
                end
            end
        end
        // Writes take effect at the completing edge only
        if (fin && pwrite_i && !err_reg) begin
            case (paddr_i)
                CTB_GSTAT_ADDR: begin
                    forced_shutdown_enable_next = pwdata_i[CTB_FORCED_SHUTDOWN_ENABLE_BIT];
                    gom_next = pwdata_i[CTB_GOM_BIT];
                    // Leaving operate with a channel still live is refused unless forced shutdown is set in the same write
                    if (gom_reg && !pwdata_i[CTB_GOM_BIT] && !pwdata_i[CTB_FORCED_SHUTDOWN_ENABLE_BIT]
                        && !init_reg) begin
                        gom_next = 1'b1;
                        gset[CTB_G_SHUT] = 1'b1;
                    end
                end
                CTB_GIEN_ADDR: gien_next = pwdata_i[3:0];
                CTB_CCTRL_ADDR: begin
                    init_next = pwdata_i[CTB_INIT_BIT];
                    if (pwdata_i[CTB_STOP_BIT]) begin
                        mode_next = CTB_STOP;
                    end else if (pwdata_i[CTB_SLEEP_BIT]) begin
                        mode_next = CTB_SLEEP;
                    end else begin
                        mode_next = CTB_RUN;
                    end
                end
                CTB_CBRP_ADDR: brp_next = pwdata_i[7:0];
                CTB_CSYNC_ADDR: sync_next = pwdata_i[15:0];
                CTB_CIEN_ADDR: cien_next = pwdata_i[2:0];
                default: begin
                    // Writing zero clears new data; writing one never sets it
                    if (is_mb && aword == CTB_W_STATE && !pwdata_i[CTB_ND_BIT]) begin
                        nd_next[abuf] = 1'b0;
                    end
                end
            endcase
        end
        // Bus activity wakes sleep but never stop
        if (mode_reg == CTB_SLEEP && rx_fall) begin
            mode_next = CTB_RUN;
        end
        // Hardware set applied after the CPU clear so it wins
        if (evt_i.rx_done && int'(evt_i.buf_idx) < NBUF) begin
            nd_next[evt_i.buf_idx] = 1'b1;
        end
        cset[CTB_C_MSG] = evt_ctrl[CTB_IE_BIT] & (evt_i.rx_done | evt_i.tx_done
            | (evt_i.remote_rx & ~evt_ctrl[CTB_ARA_BIT]));
        cset[CTB_C_BUSERR] = evt_i.bit_err | evt_i.stuff_err | evt_i.form_err
            | evt_i.crc_err | evt_i.ack_err;
        cset[CTB_C_MODE] = evt_i.ep_tx | evt_i.ep_rx | evt_i.boff_tx;
        cset[CTB_C_OVR] = evt_i.overrun;
        // Pending flags: write one to clear, a new cause wins
        gpend_next = gpend_reg | gset;
        cpend_next = cpend_reg | cset;
        if (fin && pwrite_i && !err_reg && paddr_i == CTB_GPEND_ADDR) begin
            gpend_next = (gpend_reg & ~pwdata_i[3:0]) | gset;
        end
        if (fin && pwrite_i && !err_reg && paddr_i == CTB_CPEND_ADDR) begin
            cpend_next = (cpend_reg & ~pwdata_i[3:0]) | cset;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ack_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
            {forced_shutdown_enable_reg, gom_reg} <= CTB_GSTAT_RST;
            gien_reg <= 4'h0;
            gpend_reg <= 4'h0;
            cien_reg <= 3'h0;
            cpend_reg <= 4'h0;
            init_reg <= 1'b1;
            mode_reg <= CTB_RUN;
            brp_reg <= CTB_BRP_RST;
            sync_reg <= CTB_SYNC_RST;
            burst_reg <= 1'b0;
            bbuf_reg <= '0;
            blast_reg <= 4'h0;
            nd_reg <= '0;
            for (int k = 0; k < 10; k++) begin
                tmp_reg[k] <= 16'h0000;
            end
        end else begin
            ack_reg <= ack_next;
            prdata_reg <= prdata_next;
            err_reg <= err_next;
            gom_reg <= gom_next;
            forced_shutdown_enable_reg <= forced_shutdown_enable_next;
            gien_reg <= gien_next;
            gpend_reg <= gpend_next;
            cien_reg <= cien_next;
            cpend_reg <= cpend_next;
            init_reg <= init_next;
            mode_reg <= mode_next;
            brp_reg <= brp_next;
            sync_reg <= sync_next;
            burst_reg <= burst_next;
            bbuf_reg <= bbuf_next;
            blast_reg <= blast_next;
            nd_reg <= nd_next;
            for (int k = 0; k < 10; k++) begin
                tmp_reg[k] <= tmp_next[k];
            end
        end
    end

    // Buffer memory: engine write lands after the CPU write, so it wins a clash
    always_ff @(posedge ref_clk_i) begin
        if (fin && pwrite_i && !err_reg && is_mb && aword != CTB_W_STATE) begin
            mem[mem_idx(abuf, aword)] <= pwdata_i[15:0];
        end
        if (eng_i.wr && int'(eng_i.buf_idx) < NBUF && eng_i.word <= CTB_W_IDH) begin
            mem[mem_idx(eng_i.buf_idx, eng_i.word)] <= eng_i.data;
        end
    end

    // Quantum divider and bit position counter
    logic [6:0] div_reg, div_next;
    logic [4:0] tq_cnt_reg, tq_cnt_next;
    logic tick_reg, tick_next, majority_vote_select_reg, majority_vote_select_next, bst_reg, bst_next;
    logic [2:0] sjw_reg, sjw_next;
    logic running;
    assign running = (mode_reg == CTB_RUN) & gom_reg;

    always_comb begin
        div_next = div_reg;
        tq_cnt_next = tq_cnt_reg;
        tick_next = 1'b0;
        majority_vote_select_next = 1'b0;
        bst_next = 1'b0;
        sjw_next = 3'(sync_reg[11:10]) + 3'h1;
        if (!running) begin
            // Standby or global operate off clears and holds the bit clock
            div_next = 7'h00;
            tq_cnt_next = 5'h00;
        end else if (rx_fall) begin
            // Falling edge resets the bit to its sync segment
            div_next = 7'h00;
            tq_cnt_next = 5'h00;
        end else if (div_reg >= {brp_reg[5:0], 1'b1}) begin
            div_next = 7'h00;
            tick_next = 1'b1;
            majority_vote_select_next = (tq_cnt_reg == sync_reg[9:5]);
            if (tq_cnt_reg >= sync_reg[4:0]) begin
                tq_cnt_next = 5'h00;
                bst_next = 1'b1;
            end else begin
                tq_cnt_next = tq_cnt_reg + 5'h01;
            end
        end else begin
            div_next = div_reg + 7'h01;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            div_reg <= 7'h00;
            tq_cnt_reg <= 5'h00;
            tick_reg <= 1'b0;
            majority_vote_select_reg <= 1'b0;
            bst_reg <= 1'b0;
            sjw_reg <= 3'h1;
        end else begin
            div_reg <= div_next;
            tq_cnt_reg <= tq_cnt_next;
            tick_reg <= tick_next;
            majority_vote_select_reg <= majority_vote_select_next;
            bst_reg <= bst_next;
            sjw_reg <= sjw_next;
        end
    end

    assign tq_tick_o = tick_reg;
    assign sample_o = majority_vote_select_reg;
    assign bit_start_o = bst_reg;
    assign jump_width_o = sjw_reg;
    assign standby_o = (mode_reg != CTB_RUN);
    assign global_operate_o = gom_reg;
    // Message cause carries its own gate; the rest use channel enables
    assign ch_irq_o = |(cpend_reg & {cien_reg, 1'b1});
    assign glob_irq_o = |(gpend_reg & gien_reg);

    // Cycles between quantum ticks, valid only while prescale is steady
    logic [7:0] gap_cnt;
    logic gap_ok;
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !running || rx_fall || $changed(brp_reg)) begin
            gap_cnt <= 8'h00;
            gap_ok <= 1'b0;
        end else if (tick_reg) begin
            gap_cnt <= 8'h01;
            gap_ok <= 1'b1;
        end else begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_read_cap;
        cap && !pwrite_i && !acc_err;
    endsequence
    sequence s_len_read;
        s_read_cap ##0 is_mb && aword == CTB_W_LEN;
    endsequence

    // A tick launched under the old prescale may land on the edge that sees the new one
    tq_period_a: assert property (tick_reg && gap_ok && running && !rx_fall
        && $stable(brp_reg) |-> gap_cnt == {1'b0, brp_reg[5:0], 1'b0} + 8'h02)
        else $error("quantum period wrong");
    sample_pos_a: assert property (majority_vote_select_reg |-> tq_cnt_reg == sync_reg[9:5] + 5'h01
        || tq_cnt_reg == 5'h00)
        else $error("sample point off");
    bit_len_a: assert property (tick_next && tq_cnt_reg == sync_reg[4:0]
        |=> bst_reg && tq_cnt_reg == 5'h00)
        else $error("bit time length wrong");
    jump_width_a: assert property ($changed(sync_reg) |=> jump_width_o ==
        3'($past(sync_reg[11:10])) + 3'h1)
        else $error("jump width mismatch");
    stop_hold_a: assert property (mode_reg == CTB_STOP
        && !(fin && pwrite_i && paddr_i == CTB_CCTRL_ADDR) |=> mode_reg == CTB_STOP)
        else $error("stop mode left without cpu");
    sleep_wake_a: assert property (mode_reg == CTB_SLEEP && rx_fall
        && !(fin && pwrite_i) |=> mode_reg == CTB_RUN ##1 !standby_o)
        else $error("sleep did not wake");
    nd_clear_a: assert property (|($past(nd_reg) & ~nd_reg) |->
        $past(fin && pwrite_i && is_mb && aword == CTB_W_STATE))
        else $error("new data cleared by hardware");
    burst_start_a: assert property (s_len_read ##0 !rd_byte_i |=> burst_reg
        && blast_reg == CTB_W_LEN)
        else $error("burst did not start");
    byte_nostart_a: assert property (s_len_read ##0 rd_byte_i |=> !burst_reg)
        else $error("byte read started burst");
    burst_cancel_a: assert property (cap && !pwrite_i && !burst_hit
        && !(is_mb && aword == CTB_W_LEN && !rd_byte_i) |=> !burst_reg)
        else $error("burst not cancelled");
    gom_refuse_a: assert property (fin && pwrite_i && !err_reg && paddr_i == CTB_GSTAT_ADDR
        && gom_reg && pwdata_i[1:0] == 2'b00 && !init_reg |=> gom_reg && gpend_reg[CTB_G_SHUT])
        else $error("shutdown not refused");
    undef_irq_a: assert property (cap && undef |=> gpend_reg[CTB_G_UNDEF] ##0 fin
        && pslverr_o)
        else $error("undefined access missed");
endmodule

// File: common/ctb_pkg.sv
package ctb_pkg;
    // Register byte addresses on the 12-bit APB window
    localparam logic [11:0] CTB_GSTAT_ADDR = 12'h000;
    localparam logic [11:0] CTB_GPEND_ADDR = 12'h004;
    localparam logic [11:0] CTB_GIEN_ADDR = 12'h008;
    localparam logic [11:0] CTB_CCTRL_ADDR = 12'h010;
    localparam logic [11:0] CTB_CBRP_ADDR = 12'h014;
    localparam logic [11:0] CTB_CSYNC_ADDR = 12'h018;
    localparam logic [11:0] CTB_CIEN_ADDR = 12'h01c;
    localparam logic [11:0] CTB_CPEND_ADDR = 12'h020;
    localparam logic [11:0] CTB_TMP_BASE = 12'h040;
    localparam logic [11:0] CTB_TMP_LAST = 12'h064;
    localparam logic [11:0] CTB_MB_BASE = 12'h400;
    localparam int CTB_MB_STRIDE = 64;
    // Message buffer word indices
    localparam logic [3:0] CTB_W_CONF = 4'h0;
    localparam logic [3:0] CTB_W_STATE = 4'h1;
    localparam logic [3:0] CTB_W_LEN = 4'h2;
    localparam logic [3:0] CTB_W_CTRL = 4'h3;
    localparam logic [3:0] CTB_W_IDH = 4'h9;
    // Field positions
    localparam int CTB_GOM_BIT = 0;
    localparam int CTB_FORCED_SHUTDOWN_ENABLE_BIT = 1;
    localparam int CTB_INIT_BIT = 0;
    localparam int CTB_SLEEP_BIT = 1;
    localparam int CTB_STOP_BIT = 2;
    localparam int CTB_INITST_BIT = 8;
    localparam int CTB_ISLEEP_BIT = 9;
    localparam int CTB_ISTOP_BIT = 10;
    localparam int CTB_IE_BIT = 0;
    localparam int CTB_ARA_BIT = 1;
    localparam int CTB_ND_BIT = 0;
    localparam int CTB_TLM_BIT = 7;
    localparam int CTB_SYNC_W = 16;
    localparam int CTB_BUF_W = 5;
    // Global pending bits
    localparam int CTB_G_UNDEF = 0;
    localparam int CTB_G_SHUT = 1;
    localparam int CTB_G_CHOFF = 2;
    localparam int CTB_G_TMPON = 3;
    // Channel pending bits
    localparam int CTB_C_MSG = 0;
    localparam int CTB_C_BUSERR = 1;
    localparam int CTB_C_MODE = 2;
    localparam int CTB_C_OVR = 3;
    // Reset values
    localparam logic [15:0] CTB_SYNC_RST = 16'h0000;
    localparam logic [7:0] CTB_BRP_RST = 8'h00;
    localparam logic [1:0] CTB_GSTAT_RST = 2'h0;

    typedef enum logic [2:0] {
        CTB_RUN = 3'b001,
        CTB_SLEEP = 3'b010,
        CTB_STOP = 3'b100
    } ctb_mode_e;

    // Completion and error events from the frame engine, one-cycle pulses
    typedef struct packed {
        logic rx_done;
        logic tx_done;
        logic remote_rx;
        logic [CTB_BUF_W-1:0] buf_idx;
        logic bit_err;
        logic stuff_err;
        logic form_err;
        logic crc_err;
        logic ack_err;
        logic overrun;
        logic ep_tx;
        logic ep_rx;
        logic boff_tx;
    } ctb_evt_s;

    // Engine write port into message buffer memory
    typedef struct packed {
        logic wr;
        logic [CTB_BUF_W-1:0] buf_idx;
        logic [3:0] word;
        logic [15:0] data;
    } ctb_eng_wr_s;
endpackage

// File: bench/ctb_can_model.sv
`timescale 1ns/1ps
// Far side: the bus pin and the frame engine's pulses and buffer stores
module ctb_can_model (
    input wire logic clk_i,
    output logic can_rx_o,
    output ctb_pkg::ctb_evt_s evt_o,
    output ctb_pkg::ctb_eng_wr_s eng_o
);
    import ctb_pkg::*;
    // Bus idles recessive, engine quiet
    initial begin
        can_rx_o = 1'b1;
        evt_o = '0;
        eng_o = '0;
    end
    // Event lasts exactly one cycle, as the engine sends it
    task automatic pulse(input ctb_evt_s e);
        @(posedge clk_i);
        evt_o <= e;
        @(posedge clk_i);
        evt_o <= '0;
    endtask
    // Engine store into buffer 0; sets data the way reception would
    task automatic store(input logic [3:0] w, input logic [15:0] d);
        @(posedge clk_i);
        eng_o <= '{wr: 1'b1, buf_idx: '0, word: w, data: d};
        @(posedge clk_i);
        eng_o <= '0;
    endtask
    // Dominant stretch, then settle time for the pin synchroniser
    task automatic dominant();
        @(posedge clk_i);
        can_rx_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        can_rx_o <= 1'b1;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

// File: bench/tb_ctb_top.sv
`timescale 1ns/1ps
module tb_ctb_top;
    import ctb_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdb = 1'b0;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0, prdata, rd;
    logic pready, pslverr, er, can_rx, tq, smp, bst, sb, gop, cirq, girq;
    logic [2:0] jw;
    ctb_evt_s evt;
    ctb_eng_wr_s eng;
    int errors = 0, total_checks = 0, c;
    always #50 ref_clk_i = ~ref_clk_i;
    ctb_top i_ctb_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .rd_byte_i(rdb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .can_rx_i(can_rx), .evt_i(evt), .eng_i(eng),
        .tq_tick_o(tq), .sample_o(smp), .bit_start_o(bst), .jump_width_o(jw),
        .standby_o(sb), .global_operate_o(gop), .ch_irq_o(cirq), .glob_irq_o(girq));
    ctb_can_model i_ctb_can_model (.clk_i(ref_clk_i), .can_rx_o(can_rx), .evt_o(evt),
        .eng_o(eng));
    task automatic end_of_test();
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer; ready, data and error are taken at the completing rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic b);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        rdb <= b;
        @(posedge ref_clk_i);
        pen <= 1'b1;
        // Read right after the edge, outputs still show their pre-edge values
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        rdb <= 1'b0;
        @(negedge ref_clk_i);
    endtask
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 1'b0);
        chk(n, rd, e);
    endtask
    task automatic bad(input logic [11:0] a);
        xfer(1'b0, a, 32'h0, 1'b0);
        chk("refused", 32'(er), 32'h1);
    endtask
    // Cycles until the chosen timing pulse: 0 quantum, 1 sample, 2 bit start
    task automatic gap(input int s);
        logic [2:0] v;
        c = 0;
        do begin
            @(negedge ref_clk_i);
            c++;
            v = {bst, smp, tq};
        end while (v[s] !== 1'b1 && c < 200);
        if (v[s] !== 1'b1) begin
            errors++;
            end_of_test();
        end
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        chk("jump", 32'(jw), 32'h1);
        rdc("gstat", CTB_GSTAT_ADDR, 32'h0);
        bad(CTB_CCTRL_ADDR);
        bad(12'h00c);
        xfer(1'b1, CTB_GSTAT_ADDR, 32'h1, 1'b0);
        rdc("sync", CTB_CSYNC_ADDR, 32'(CTB_SYNC_RST));
        // Prescale 1, bit 8 quanta, sample at 5, jump 3: inside the legal limits
        xfer(1'b1, CTB_CBRP_ADDR, 32'h1, 1'b0);
        xfer(1'b1, CTB_CSYNC_ADDR, 32'h0887, 1'b0);
        xfer(1'b1, CTB_CCTRL_ADDR, 32'h0, 1'b0);
        rdc("sync", CTB_CSYNC_ADDR, 32'h0887);
        chk("jump", 32'(jw), 32'h3);
        gap(2);
        gap(1);
        chk("sample", c, 20);
        gap(2);
        chk("bit", c, 12);
        gap(0);
        chk("quantum", c, 4);
        bad(CTB_TMP_BASE + 12'h8);
        xfer(1'b1, CTB_GSTAT_ADDR, 32'h0, 1'b0);
        chk("operate", 32'(gop), 32'h1);
        rdc("gpend", CTB_GPEND_ADDR, 32'hf);
        xfer(1'b1, CTB_GIEN_ADDR, 32'hf, 1'b0);
        chk("girq", 32'(girq), 32'h1);
        xfer(1'b1, CTB_GPEND_ADDR, 32'hf, 1'b0);
        chk("girq", 32'(girq), 32'h0);
        // Buffer changes under a running burst must not show through
        i_ctb_can_model.store(4'h2, 16'h0008);
        i_ctb_can_model.store(4'h3, 16'h0003);
        rdc("len", CTB_MB_BASE + 12'h8, 32'h8);
        i_ctb_can_model.store(4'h3, 16'h0001);
        rdc("ctrl", CTB_MB_BASE + 12'hc, 32'h3);
        rdc("ctrl", CTB_MB_BASE + 12'hc, 32'h1);
        xfer(1'b0, CTB_MB_BASE + 12'h8, 32'h0, 1'b1);
        i_ctb_can_model.store(4'h3, 16'h0003);
        rdc("ctrl", CTB_MB_BASE + 12'hc, 32'h3);
        // Auto answer set: remote frame silent; overrun pends but stays masked
        i_ctb_can_model.pulse('{remote_rx: 1'b1, default: 0});
        i_ctb_can_model.pulse('{overrun: 1'b1, default: 0});
        rdc("cpend", CTB_CPEND_ADDR, 32'h8);
        chk("cirq", 32'(cirq), 32'h0);
        i_ctb_can_model.pulse('{rx_done: 1'b1, default: 0});
        @(negedge ref_clk_i);
        chk("cirq", 32'(cirq), 32'h1);
        // New data shows after reception and goes only on a CPU write of zero
        rdc("newdata", CTB_MB_BASE + 12'h4, 32'h1);
        xfer(1'b1, CTB_MB_BASE + 12'h4, 32'h0, 1'b0);
        rdc("newdata", CTB_MB_BASE + 12'h4, 32'h0);
        // Only bus errors enabled: error state pends silently, a bus error with a send completion rings
        xfer(1'b1, CTB_CPEND_ADDR, 32'hf, 1'b0);
        xfer(1'b1, CTB_CIEN_ADDR, 32'h1, 1'b0);
        i_ctb_can_model.pulse('{ep_rx: 1'b1, default: 0});
        @(negedge ref_clk_i);
        chk("cirq", 32'(cirq), 32'h0);
        i_ctb_can_model.pulse('{crc_err: 1'b1, tx_done: 1'b1, default: 0});
        rdc("cpend", CTB_CPEND_ADDR, 32'h7);
        chk("cirq", 32'(cirq), 32'h1);
        xfer(1'b1, CTB_CCTRL_ADDR, 32'h4, 1'b0);
        i_ctb_can_model.dominant();
        chk("stop", 32'(sb), 32'h1);
        xfer(1'b1, CTB_CCTRL_ADDR, 32'h2, 1'b0);
        chk("sleep", 32'(sb), 32'h1);
        i_ctb_can_model.dominant();
        for (c = 0; c < 50 && sb !== 1'b0; c++) @(negedge ref_clk_i);
        chk("wake", 32'(sb), 32'h0);
        end_of_test();
    end
endmodule
